//--- verilog/rcr_regs.v
// Regulator-1 configuration registers behind a serial management bus slave.
// Assumes SCL and SDA come from pins (resynchronised here) and that the
// SDA wire is open drain, pulled high outside; the bus runs far below 40 MHz.
`include "rcr_map.vh"

module rcr_regs #(
  parameter STEP_CYCLES = `RCR_STEP_CYCLES,
  parameter [6:0] MAIN_ADDR = `RCR_MAIN_ADDR_DEF
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire i_scl,
  input wire i_sda,
  output wire o_sda_out,
  output wire o_sda_oe,
  input wire i_nvm_load,
  input wire [6:0] i_nvm_rtc_addr,
  input wire [2:0] i_nvm_enables,
  input wire [5:0] i_nvm_active,
  input wire [5:0] i_nvm_sleep,
  input wire [6:0] i_nvm_on_wait,
  input wire [6:0] i_nvm_off_wait,
  input wire i_sleep_state,
  input wire i_seq_on_start,
  input wire i_seq_off_start,
  output wire [6:0] o_rtc_addr,
  output wire o_rtc_sel,
  output wire o_reg1_phase_lock_on,
  output wire o_reg1_spread_on,
  output wire o_reg1_ultrasonic_on,
  output wire [1:0] o_reg1_run_mode_awake,
  output wire [3:0] o_reg1_voltage_awake,
  output wire [1:0] o_reg1_run_mode_dozing,
  output wire [3:0] o_reg1_voltage_dozing,
  output wire [6:0] o_reg1_turn_on_wait,
  output wire [6:0] o_reg1_turn_off_wait,
  output wire [1:0] o_reg1_mode_now,
  output wire [3:0] o_reg1_voltage_now,
  output wire o_reg1_enable
);

  // ----------
  // Bus state codes
  // ----------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_ADDR = 7'h02;
  localparam [6:0] ST_ACK_A = 7'h04;
  localparam [6:0] ST_WRITE = 7'h08;
  localparam [6:0] ST_ACK_W = 7'h10;
  localparam [6:0] ST_READ = 7'h20;
  localparam [6:0] ST_ACK_R = 7'h40;

  // Configuration storage
  reg [6:0] rtc_addr_r;
  reg [2:0] enables_r;
  reg [1:0] mode_awake_r;
  reg [3:0] volt_awake_r;
  reg [1:0] mode_dozing_r;
  reg [3:0] volt_dozing_r;
  reg [6:0] on_wait_r;
  reg [6:0] off_wait_r;
  reg [1:0] mode_now_r;
  reg [3:0] volt_now_r;
  reg enable_r;

  // Pin synchronisers and bus engine
  reg scl_s1_r, scl_s2_r, scl_s3_r;
  reg sda_s1_r, sda_s2_r, sda_s3_r;
  reg [6:0] state_r;
  reg [2:0] bit_cnt_r;
  reg got_byte_r;
  reg [7:0] shift_r;
  reg [7:0] tx_r;
  reg [7:0] ptr_r;
  reg first_r;
  reg rw_r;
  reg rtc_sel_r;
  reg master_ack_r;
  reg sda_oe_r;
  reg sda_out_r;

  wire scl_rise;
  wire scl_fall;
  wire bus_start;
  wire bus_stop;
  wire [6:0] rtc_addr_eff;
  wire wr_commit;
  wire fire_on;
  wire fire_off;
  reg [7:0] rd_byte;

  // ----------
  // Pin synchronisers
  // ----------
  // Three flops per pin; only the second and third stages are decoded.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      scl_s1_r <= 1'b1;
      scl_s2_r <= 1'b1;
      scl_s3_r <= 1'b1;
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      sda_s3_r <= 1'b1;
    end else if (i_clk_en) begin
      scl_s1_r <= i_scl;
      scl_s2_r <= scl_s1_r;
      scl_s3_r <= scl_s2_r;
      sda_s1_r <= i_sda;
      sda_s2_r <= sda_s1_r;
      sda_s3_r <= sda_s2_r;
    end
  end

  assign scl_rise = scl_s2_r & ~scl_s3_r;
  assign scl_fall = ~scl_s2_r & scl_s3_r;
  // SDA moving while SCL stays high marks a frame boundary
  assign bus_start = scl_s2_r & scl_s3_r & sda_s3_r & ~sda_s2_r;
  assign bus_stop = scl_s2_r & scl_s3_r & ~sda_s3_r & sda_s2_r;

  // Calendar address: the all-zero field stands for the fixed default
  assign rtc_addr_eff = (rtc_addr_r == 7'h00) ? `RCR_RTC_ADDR_ZERO : rtc_addr_r;

  // A data byte after the pointer byte, addressed to the main slave
  assign wr_commit = (state_r == ST_WRITE) & scl_fall & got_byte_r & ~first_r & ~rtc_sel_r;

  // ----------
  // Read data mux
  // ----------
  // Unused bits and unmapped indices read as zero.
  always @* begin
    rd_byte = 8'h00;
    case (ptr_r)
      `RCR_IDX_RTC_ADDR: rd_byte = {1'b0, rtc_addr_r};
      `RCR_IDX_ENABLES: rd_byte = {3'h0, enables_r[2], enables_r[1], enables_r[0], 2'h0};
      `RCR_IDX_ACTIVE: rd_byte = {2'h0, mode_awake_r, volt_awake_r};
      `RCR_IDX_SLEEP: rd_byte = {2'h0, mode_dozing_r, volt_dozing_r};
      `RCR_IDX_ON_WAIT: rd_byte = {1'b0, on_wait_r};
      `RCR_IDX_OFF_WAIT: rd_byte = {1'b0, off_wait_r};
      default: rd_byte = 8'h00;
    endcase
  end

  // ----------
  // Serial bus slave
  // ----------
  // Bits are sampled on SCL rise and driven after SCL fall, so SDA only
  // changes while SCL is low. First written byte is the register pointer,
  // which then steps by one per data byte in either direction, except on calendar reads.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 3'h0;
      got_byte_r <= 1'b0;
      shift_r <= 8'h00;
      tx_r <= 8'h00;
      ptr_r <= 8'h00;
      first_r <= 1'b0;
      rw_r <= 1'b0;
      rtc_sel_r <= 1'b0;
      master_ack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      sda_out_r <= 1'b0;
    end else if (i_clk_en) begin
      if (bus_start) begin
        state_r <= ST_ADDR;
        bit_cnt_r <= 3'h0;
        got_byte_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else if (bus_stop) begin
        state_r <= ST_IDLE;
        rtc_sel_r <= 1'b0;
        sda_oe_r <= 1'b0;
      end else begin
        case (state_r)
          ST_ADDR, ST_WRITE: begin
            if (scl_rise) begin
              shift_r <= {shift_r[6:0], sda_s2_r};
              bit_cnt_r <= bit_cnt_r + 3'h1;
              got_byte_r <= (bit_cnt_r == 3'h7);
            end else if (scl_fall && got_byte_r) begin
              got_byte_r <= 1'b0;
              if (state_r == ST_ADDR) begin
                rw_r <= shift_r[0];
                if (shift_r[7:1] == rtc_addr_eff || shift_r[7:1] == MAIN_ADDR) begin
                  state_r <= ST_ACK_A;
                  rtc_sel_r <= (shift_r[7:1] == rtc_addr_eff);
                  sda_oe_r <= 1'b1;
                end else begin
                  state_r <= ST_IDLE; // Not ours: stay silent until next start
                end
              end else begin
                state_r <= ST_ACK_W;
                sda_oe_r <= 1'b1;
                if (first_r) begin
                  ptr_r <= shift_r;
                  first_r <= 1'b0;
                end else begin
                  ptr_r <= ptr_r + 8'h01;
                end
              end
            end
          end
          ST_ACK_A: begin
            if (scl_fall) begin
              bit_cnt_r <= 3'h0;
              first_r <= 1'b1;
              if (rw_r) begin
                // Calendar reads: this slice releases bit 7 and pulls the other bits low (0x80)
                tx_r <= rtc_sel_r ? 8'h00 : rd_byte;
                sda_oe_r <= rtc_sel_r ? 1'b0 : ~rd_byte[7];
                if (!rtc_sel_r) begin
                  ptr_r <= ptr_r + 8'h01;
                end
                state_r <= ST_READ;
              end else begin
                sda_oe_r <= 1'b0;
                state_r <= ST_WRITE;
              end
            end
          end
          ST_ACK_W: begin
            if (scl_fall) begin
              sda_oe_r <= 1'b0;
              bit_cnt_r <= 3'h0;
              state_r <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 3'h1;
              got_byte_r <= (bit_cnt_r == 3'h7);
            end else if (scl_fall) begin
              if (got_byte_r) begin
                got_byte_r <= 1'b0;
                sda_oe_r <= 1'b0; // Free the line for the master's answer
                state_r <= ST_ACK_R;
              end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sda_oe_r <= ~tx_r[6];
              end
            end
          end
          ST_ACK_R: begin
            if (scl_rise) begin
              master_ack_r <= ~sda_s2_r;
            end else if (scl_fall) begin
              if (master_ack_r) begin
                bit_cnt_r <= 3'h0;
                tx_r <= rtc_sel_r ? 8'h00 : rd_byte;
                sda_oe_r <= rtc_sel_r ? 1'b0 : ~rd_byte[7];
                if (!rtc_sel_r) begin
                  ptr_r <= ptr_r + 8'h01;
                end
                state_r <= ST_READ;
              end else begin
                state_r <= ST_IDLE; // Master ended the read
              end
            end
          end
          ST_IDLE: begin
            sda_oe_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            sda_oe_r <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------
  // Configuration registers
  // ----------
  // Reset gives the documented defaults; the non-volatile load then wins
  // over a bus write in the same cycle, since it only comes at power-up.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rtc_addr_r <= `RCR_RST_RTC_ADDR;
      enables_r <= `RCR_RST_ENABLES;
      mode_awake_r <= `RCR_RST_MODE;
      volt_awake_r <= `RCR_RST_VOLT;
      mode_dozing_r <= `RCR_RST_MODE;
      volt_dozing_r <= `RCR_RST_VOLT;
      on_wait_r <= `RCR_RST_ON_WAIT;
      off_wait_r <= `RCR_RST_OFF_WAIT;
    end else if (i_clk_en) begin
      if (i_nvm_load) begin
        rtc_addr_r <= i_nvm_rtc_addr;
        enables_r <= i_nvm_enables;
        mode_awake_r <= i_nvm_active[5:4];
        volt_awake_r <= i_nvm_active[3:0];
        mode_dozing_r <= i_nvm_sleep[5:4];
        volt_dozing_r <= i_nvm_sleep[3:0];
        on_wait_r <= i_nvm_on_wait;
        off_wait_r <= i_nvm_off_wait;
      end else if (wr_commit) begin
        // Only the used bits are stored
        case (ptr_r)
          `RCR_IDX_RTC_ADDR: rtc_addr_r <= shift_r[6:0];
          `RCR_IDX_ENABLES: begin
            enables_r[2] <= shift_r[`RCR_EN_PHASE_BIT];
            enables_r[1] <= shift_r[`RCR_EN_ULTRA_BIT];
            enables_r[0] <= shift_r[`RCR_EN_SPREAD_BIT];
          end
          `RCR_IDX_ACTIVE: begin
            mode_awake_r <= shift_r[`RCR_MODE_MSB:`RCR_MODE_LSB];
            volt_awake_r <= shift_r[`RCR_VOLT_MSB:`RCR_VOLT_LSB];
          end
          `RCR_IDX_SLEEP: begin
            mode_dozing_r <= shift_r[`RCR_MODE_MSB:`RCR_MODE_LSB];
            volt_dozing_r <= shift_r[`RCR_VOLT_MSB:`RCR_VOLT_LSB];
          end
          `RCR_IDX_ON_WAIT: on_wait_r <= shift_r[`RCR_WAIT_MSB:0];
          `RCR_IDX_OFF_WAIT: off_wait_r <= shift_r[`RCR_WAIT_MSB:0];
          default: rtc_addr_r <= rtc_addr_r; // Unmapped: write dropped
        endcase
      end
    end
  end

  // ----------
  // Applied setting and regulator enable
  // ----------
  // Reserved mode codes fall back to automatic so the power stage never
  // sees an undefined mode; the stored field still reads back as written.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      mode_now_r <= `RCR_MODE_AUTO;
      volt_now_r <= `RCR_RST_VOLT;
      enable_r <= 1'b0;
    end else if (i_clk_en) begin
      if (i_sleep_state) begin
        mode_now_r <= mode_dozing_r[1] ? `RCR_MODE_AUTO : mode_dozing_r;
        volt_now_r <= volt_dozing_r;
      end else begin
        mode_now_r <= mode_awake_r[1] ? `RCR_MODE_AUTO : mode_awake_r;
        volt_now_r <= volt_awake_r;
      end
      if (fire_off) begin
        enable_r <= 1'b0;
      end else if (fire_on) begin
        enable_r <= 1'b1;
      end
    end
  end

  // Sequence delays count whole milliseconds from the sequence start
  rcr_seq_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_seq_timer (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_clk_en(i_clk_en),
    .i_start_on(i_seq_on_start),
    .i_start_off(i_seq_off_start),
    .i_on_wait(on_wait_r),
    .i_off_wait(off_wait_r),
    .o_fire_on_r(fire_on),
    .o_fire_off_r(fire_off)
  );

  // ----------
  // Output wiring, all from flops
  // ----------
  assign o_sda_out = sda_out_r;
  assign o_sda_oe = sda_oe_r;
  assign o_rtc_addr = rtc_addr_r;
  assign o_rtc_sel = rtc_sel_r;
  assign o_reg1_phase_lock_on = enables_r[2];
  assign o_reg1_spread_on = enables_r[0];
  assign o_reg1_ultrasonic_on = enables_r[1];
  assign o_reg1_run_mode_awake = mode_awake_r;
  assign o_reg1_voltage_awake = volt_awake_r;
  assign o_reg1_run_mode_dozing = mode_dozing_r;
  assign o_reg1_voltage_dozing = volt_dozing_r;
  assign o_reg1_turn_on_wait = on_wait_r;
  assign o_reg1_turn_off_wait = off_wait_r;
  assign o_reg1_mode_now = mode_now_r;
  assign o_reg1_voltage_now = volt_now_r;
  assign o_reg1_enable = enable_r;

endmodule

//--- pkg/rcr_map.vh
// Constants of the regulator-1 configuration slice: register indices,
// field positions, reset values, mode codes and timing counts.
// Assumes it is included by bare name from each design file that needs it.
`ifndef RCR_MAP_VH
`define RCR_MAP_VH

// ----------
// Register indices on the serial management bus
// ----------
`define RCR_IDX_RTC_ADDR 8'h13
`define RCR_IDX_ENABLES 8'h14
`define RCR_IDX_ACTIVE 8'h15
`define RCR_IDX_SLEEP 8'h16
`define RCR_IDX_ON_WAIT 8'h17
`define RCR_IDX_OFF_WAIT 8'h18

// ----------
// Field positions
// ----------
`define RCR_EN_PHASE_BIT 4
`define RCR_EN_ULTRA_BIT 3
`define RCR_EN_SPREAD_BIT 2
`define RCR_MODE_MSB 5
`define RCR_MODE_LSB 4
`define RCR_VOLT_MSB 3
`define RCR_VOLT_LSB 0
`define RCR_WAIT_MSB 6

// ----------
// Reset values, used until the non-volatile copy is loaded
// ----------
`define RCR_RST_RTC_ADDR 7'h00
`define RCR_RST_ENABLES 3'h0
`define RCR_RST_MODE 2'h0
`define RCR_RST_VOLT 4'h6
`define RCR_RST_ON_WAIT 7'h02
`define RCR_RST_OFF_WAIT 7'h3C

// ----------
// Addresses and mode codes
// ----------
`define RCR_RTC_ADDR_ZERO 7'h6F
`define RCR_MAIN_ADDR_DEF 7'h12
`define RCR_MODE_AUTO 2'h0
`define RCR_MODE_FPWM 2'h1

// ----------
// Timing: one delay step, in nanoseconds, and its length in clocks
// ----------
`define RCR_CLK_PERIOD_NS 25
`define RCR_STEP_NS 1000000
`define RCR_STEP_CYCLES (`RCR_STEP_NS / `RCR_CLK_PERIOD_NS)

`endif

//--- verilog/rcr_seq_timer.v
// Millisecond delay timer for the regulator turn-on and turn-off sequence.
// Assumes start strobes are one-cycle pulses from logic on the same clock.
`include "rcr_map.vh"

module rcr_seq_timer #(
  parameter STEP_CYCLES = `RCR_STEP_CYCLES
) (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire i_start_on,
  input wire i_start_off,
  input wire [6:0] i_on_wait,
  input wire [6:0] i_off_wait,
  output reg o_fire_on_r,
  output reg o_fire_off_r
);

  reg pending_r;
  reg dir_on_r;
  reg [6:0] left_r;
  reg [31:0] pre_r;

  // ----------
  // Delay count
  // ----------
  // A new start restarts the wait, so the delay always counts from the
  // latest sequence start; off wins when both start together.
  always @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      pending_r <= 1'b0;
      dir_on_r <= 1'b0;
      left_r <= 7'h00;
      pre_r <= 32'h00000000;
      o_fire_on_r <= 1'b0;
      o_fire_off_r <= 1'b0;
    end else if (i_clk_en) begin
      o_fire_on_r <= 1'b0;
      o_fire_off_r <= 1'b0;
      if (i_start_off || i_start_on) begin
        pending_r <= 1'b1;
        dir_on_r <= ~i_start_off;
        left_r <= i_start_off ? i_off_wait : i_on_wait;
        pre_r <= 32'h00000000;
      end else if (pending_r) begin
        if (left_r == 7'h00) begin
          pending_r <= 1'b0;
          o_fire_on_r <= dir_on_r;
          o_fire_off_r <= ~dir_on_r;
        end else if (pre_r == STEP_CYCLES - 1) begin
          pre_r <= 32'h00000000;
          left_r <= left_r - 7'h01; // One millisecond gone
        end else begin
          pre_r <= pre_r + 32'h00000001;
        end
      end
    end
  end

endmodule

//--- verif/rcr_host_model.sv
// Host model: an I2C master on the management bus of the regulator slice.
// Assumes the testbench resolves the open-drain SDA wire and feeds it back.
module rcr_host_model (
  input wire i_sys_clk,
  input wire i_sda,
  output logic o_scl = 1'b1, // Idle bus: both lines released
  output logic o_sda_low = 1'b0
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------
  // Bus phases
  // ----------
  // Ten clocks per phase; the slave needs three to act on each edge
  task automatic wait_ph();
    repeat (10) @(posedge i_sys_clk);
    #1;
  endtask
  task automatic bit_io(input logic b, output logic r);
    o_sda_low = !b;
    wait_ph();
    o_scl = 1'b1;
    wait_ph();
    r = i_sda;
    o_scl = 1'b0;
  endtask
  // Also serves as repeated start, since SDA is released first
  task automatic start();
    o_sda_low = 1'b0;
    wait_ph();
    o_scl = 1'b1;
    wait_ph();
    o_sda_low = 1'b1;
    wait_ph();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    o_sda_low = 1'b1;
    wait_ph();
    o_scl = 1'b1;
    wait_ph();
    o_sda_low = 1'b0;
    wait_ph();
  endtask
  // MSB first; ninth bit is released by the sender, pulled by the receiver
  task automatic byte_io(input logic [7:0] tx, input logic last, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
    bit_io(last, a);
    ack = !a;
  endtask
  task automatic wr_reg(input logic [6:0] dev, input logic [7:0] idx, input logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    byte_io(idx, 1'b1, rx, a1);
    byte_io(dat, 1'b1, rx, a2);
    stop();
    ok = a0 && a1 && a2;
  endtask
  // One byte read, ended by a NACK as a master must
  task automatic rd_reg(input logic [6:0] dev, input logic [7:0] idx, output logic [7:0] dat, output logic ok);
    logic [7:0] rx;
    logic a0, a1, a2, a3;
    start();
    byte_io({dev, 1'b0}, 1'b1, rx, a0);
    byte_io(idx, 1'b1, rx, a1);
    start();
    byte_io({dev, 1'b1}, 1'b1, rx, a2);
    byte_io(8'hFF, 1'b1, dat, a3);
    stop();
    ok = a0 && a1 && a2;
  endtask
endmodule

//--- verif/rcr_regs_assertions.sv
// Checker for the regulator-1 configuration slice, bound to rcr_regs.
// Assumes one clock domain; it sees only the slice's ports.
module rcr_regs_chk (
  input wire i_sys_clk,
  input wire i_rst,
  input wire i_clk_en,
  input wire i_nvm_load,
  input wire [6:0] i_nvm_rtc_addr,
  input wire [2:0] i_nvm_enables,
  input wire [6:0] i_nvm_on_wait,
  input wire [6:0] i_nvm_off_wait,
  input wire i_sleep_state,
  input wire i_seq_on_start,
  input wire i_seq_off_start,
  input wire o_sda_oe,
  input wire [6:0] o_rtc_addr,
  input wire o_rtc_sel,
  input wire o_reg1_phase_lock_on,
  input wire o_reg1_spread_on,
  input wire o_reg1_ultrasonic_on,
  input wire [1:0] o_reg1_run_mode_awake,
  input wire [3:0] o_reg1_voltage_awake,
  input wire [1:0] o_reg1_run_mode_dozing,
  input wire [3:0] o_reg1_voltage_dozing,
  input wire [6:0] o_reg1_turn_on_wait,
  input wire [6:0] o_reg1_turn_off_wait,
  input wire [1:0] o_reg1_mode_now,
  input wire [3:0] o_reg1_voltage_now,
  input wire o_reg1_enable
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (i_rst);
  // ----------
  // Properties
  // ----------
  // Calendar selection must be answered by an acknowledge
  property p_rtc_ack; $rose(o_rtc_sel) |-> ##[0:20] o_sda_oe; endproperty
  a_rtc_ack: assert property (p_rtc_ack) else $error("calendar select not acked");
  // Enables come straight from the stored copy on a load
  property p_phase; i_nvm_load && i_clk_en |=> o_reg1_phase_lock_on == $past(i_nvm_enables[2]); endproperty
  a_phase: assert property (p_phase) else $error("phase enable wrong");
  property p_spread; i_nvm_load && i_clk_en |=> o_reg1_spread_on == $past(i_nvm_enables[0]); endproperty
  a_spread: assert property (p_spread) else $error("spread enable wrong");
  property p_ultra; i_nvm_load && i_clk_en |=> o_reg1_ultrasonic_on == $past(i_nvm_enables[1]); endproperty
  a_ultra: assert property (p_ultra) else $error("ultrasonic enable wrong");
  // Applied setting lags the selection by one cycle; reserved modes apply as auto
  property p_mode_aw; i_clk_en && !i_sleep_state |=> o_reg1_mode_now ==
    ($past(o_reg1_run_mode_awake[1]) ? 2'h0 : $past(o_reg1_run_mode_awake)); endproperty
  a_mode_aw: assert property (p_mode_aw) else $error("awake mode not applied");
  property p_volt_aw; i_clk_en && !i_sleep_state |=> o_reg1_voltage_now == $past(o_reg1_voltage_awake); endproperty
  a_volt_aw: assert property (p_volt_aw) else $error("awake voltage not applied");
  property p_mode_dz; i_clk_en && i_sleep_state |=> o_reg1_mode_now ==
    ($past(o_reg1_run_mode_dozing[1]) ? 2'h0 : $past(o_reg1_run_mode_dozing)); endproperty
  a_mode_dz: assert property (p_mode_dz) else $error("dozing mode not applied");
  property p_volt_dz; i_clk_en && i_sleep_state |=> o_reg1_voltage_now == $past(o_reg1_voltage_dozing); endproperty
  a_volt_dz: assert property (p_volt_dz) else $error("dozing voltage not applied");
  // Zero wait: regulator on two cycles after the start edge, unless restarted
  property p_on0; i_seq_on_start && !i_seq_off_start && i_clk_en && o_reg1_turn_on_wait == 7'h00
    ##1 (i_clk_en && !i_seq_on_start && !i_seq_off_start)[*2] |=> o_reg1_enable; endproperty
  a_on0: assert property (p_on0) else $error("zero wait turn-on late");
  property p_load; i_nvm_load && i_clk_en |=> o_rtc_addr == $past(i_nvm_rtc_addr) &&
    o_reg1_turn_on_wait == $past(i_nvm_on_wait) && o_reg1_turn_off_wait == $past(i_nvm_off_wait); endproperty
  a_load: assert property (p_load) else $error("stored copy not loaded");
endmodule

bind rcr_regs rcr_regs_chk u_rcr_regs_chk (.i_sys_clk, .i_rst, .i_clk_en, .i_nvm_load, .i_nvm_rtc_addr,
  .i_nvm_enables, .i_nvm_on_wait, .i_nvm_off_wait, .i_sleep_state, .i_seq_on_start, .i_seq_off_start,
  .o_sda_oe, .o_rtc_addr, .o_rtc_sel, .o_reg1_phase_lock_on, .o_reg1_spread_on, .o_reg1_ultrasonic_on,
  .o_reg1_run_mode_awake, .o_reg1_voltage_awake, .o_reg1_run_mode_dozing, .o_reg1_voltage_dozing,
  .o_reg1_turn_on_wait, .o_reg1_turn_off_wait, .o_reg1_mode_now, .o_reg1_voltage_now, .o_reg1_enable);

//--- verif/rcr_regs_tb_top.sv
// Self-checking bench for the regulator-1 configuration slice.
// Assumes the host model and the bound checker; SDA is open drain, pulled up here.
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) begin \
      bad_count++; \
      $display("[ERR] t=%0t got=%0h exp=%0h", $time, (g), (e)); \
    end \
  end
module rcr_regs_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int STEP = 4;
  localparam logic [6:0] MAIN = 7'h12;
  logic i_sys_clk, i_rst, i_clk_en, i_nvm_load, i_sleep_state, i_seq_on_start, i_seq_off_start;
  logic [6:0] nvm_rtc, nvm_on, nvm_off;
  logic [2:0] nvm_en;
  logic [5:0] nvm_act, nvm_slp;
  logic scl, sda_low, ok;
  logic [7:0] d, x, r;
  wire sda_wire, sda_oe, rtc_sel, ph, sp, ul, enable;
  wire [6:0] rtc_addr, on_w, off_w;
  wire [1:0] m_aw, m_dz, m_now;
  wire [3:0] v_aw, v_dz, v_now;
  int bad_count, n_compared, seed, k, sel_cnt;
  // ----------
  // Structure
  // ----------
  // Pull-up: the wire is low whenever either party pulls it
  assign sda_wire = !(sda_low || sda_oe);
  rcr_regs #(.STEP_CYCLES(STEP), .MAIN_ADDR(MAIN)) u_rcr_regs (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_clk_en(i_clk_en), .i_scl(scl), .i_sda(sda_wire), .o_sda_out(), .o_sda_oe(sda_oe), .i_nvm_load(i_nvm_load),
    .i_nvm_rtc_addr(nvm_rtc), .i_nvm_enables(nvm_en), .i_nvm_active(nvm_act), .i_nvm_sleep(nvm_slp),
    .i_nvm_on_wait(nvm_on), .i_nvm_off_wait(nvm_off), .i_sleep_state(i_sleep_state),
    .i_seq_on_start(i_seq_on_start), .i_seq_off_start(i_seq_off_start), .o_rtc_addr(rtc_addr),
    .o_rtc_sel(rtc_sel), .o_reg1_phase_lock_on(ph), .o_reg1_spread_on(sp), .o_reg1_ultrasonic_on(ul),
    .o_reg1_run_mode_awake(m_aw), .o_reg1_voltage_awake(v_aw), .o_reg1_run_mode_dozing(m_dz),
    .o_reg1_voltage_dozing(v_dz), .o_reg1_turn_on_wait(on_w), .o_reg1_turn_off_wait(off_w),
    .o_reg1_mode_now(m_now), .o_reg1_voltage_now(v_now), .o_reg1_enable(enable));
  rcr_host_model u_rcr_host_model (.i_sys_clk(i_sys_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));
  // 40 MHz system clock
  initial begin
    i_sys_clk = 1'b0;
    forever #12.5 i_sys_clk = ~i_sys_clk;
  end
  // Counts cycles with the calendar selected; only this process writes it
  always @(posedge i_sys_clk) if (rtc_sel === 1'b1) sel_cnt <= sel_cnt + 1;
  // Cuts a hang short; the whole run needs about a fifth of this
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    bad_count++;
    give_verdict();
  end
  // ----------
  // Helpers
  // ----------
  function automatic logic [1:0] applied(input logic [1:0] m);
    return m[1] ? 2'h0 : m;
  endfunction
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Starts a sequence, optionally freezes the clock enable, counts edges to the change
  task automatic seq_run(input logic off, input int frz, input logic [6:0] n);
    logic tgt;
    tgt = !off;
    if (off) i_seq_off_start = 1'b1;
    else i_seq_on_start = 1'b1;
    @(posedge i_sys_clk);
    #1;
    {i_seq_on_start, i_seq_off_start} = 2'b00;
    i_clk_en = (frz == 0);
    k = 0;
    while (enable !== tgt && k < 1000) begin
      @(posedge i_sys_clk);
      #1;
      k++;
      if (k == frz) i_clk_en = 1'b1;
    end
    `CHK(k, n * STEP + 2 + frz)
  endtask
  // ----------
  // Main sequence
  // ----------
  initial begin
    seed = 32'hF568;
    {i_rst, i_clk_en, i_nvm_load, i_sleep_state, i_seq_on_start, i_seq_off_start} = 6'h30;
    {nvm_rtc, nvm_en, nvm_act, nvm_slp, nvm_on, nvm_off, bad_count, n_compared, k} = '0;
    repeat (4) @(posedge i_sys_clk);
    #1;
    i_rst = 1'b0;
    `CHK({m_aw, v_aw, m_dz, v_dz, ph, sp, ul, enable}, 16'h1860)
    `CHK({on_w, off_w}, {7'h02, 7'h3C})
    u_rcr_host_model.rd_reg(MAIN, 8'h18, r, ok);
    `CHK({ok, r}, 9'h13C)
    // Random stored copy; short off wait keeps the run brief
    {nvm_rtc, nvm_en, nvm_act, nvm_slp, nvm_on, nvm_off} = 36'({$random(seed), $random(seed)});
    nvm_off[6:3] = 4'h0;
    if (nvm_rtc == MAIN) nvm_rtc = 7'h25; // Calendar must not shadow the main address
    i_nvm_load = 1'b1;
    @(posedge i_sys_clk);
    #1;
    i_nvm_load = 1'b0;
    `CHK({rtc_addr, ph, ul, sp, on_w, off_w}, {nvm_rtc, nvm_en, nvm_on, nvm_off})
    `CHK({m_aw, v_aw, m_dz, v_dz}, {nvm_act, nvm_slp})
    // One enable at a time, with every unused bit written high
    for (int i = 2; i <= 4; i++) begin
      u_rcr_host_model.wr_reg(MAIN, 8'h14, 8'hE3 | (8'h01 << i), ok);
      `CHK({ph, ul, sp}, 3'b001 << (i - 2))
      u_rcr_host_model.rd_reg(MAIN, 8'h14, r, ok);
      `CHK({ok, r}, {1'b1, 8'h01 << i})
    end
    // Random settings, the first with a reserved awake mode
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed));
      x = 8'($random(seed));
      if (i == 0) d[5:4] = 2'h2;
      u_rcr_host_model.wr_reg(MAIN, 8'h15, d, ok);
      u_rcr_host_model.wr_reg(MAIN, 8'h16, x, ok);
      `CHK({m_aw, v_aw, m_dz, v_dz}, {d[5:0], x[5:0]})
      i_sleep_state = i[0];
      repeat (2) @(posedge i_sys_clk);
      #1;
      `CHK({m_now, v_now}, i[0] ? {applied(x[5:4]), x[3:0]} : {applied(d[5:4]), d[3:0]})
      u_rcr_host_model.rd_reg(MAIN, 8'h15, r, ok);
      `CHK({ok, r}, {3'b100, d[5:0]})
    end
    // Calendar address: zero field means 0x6F, any other is taken as is
    u_rcr_host_model.wr_reg(MAIN, 8'h13, 8'h00, ok);
    k = sel_cnt;
    u_rcr_host_model.wr_reg(7'h6F, 8'h00, 8'h55, ok);
    `CHK({ok, sel_cnt > k}, 2'b11)
    d = 8'($random(seed)) & 8'h7F;
    if (d == 8'h00 || d == 8'h12 || d == 8'h6F) d = 8'h25;
    u_rcr_host_model.wr_reg(MAIN, 8'h13, d | 8'h80, ok);
    u_rcr_host_model.rd_reg(MAIN, 8'h13, r, ok);
    `CHK({ok, r}, {1'b1, d})
    k = sel_cnt;
    u_rcr_host_model.wr_reg(d[6:0], 8'h00, 8'h00, ok);
    `CHK({ok, sel_cnt > k}, 2'b11)
    u_rcr_host_model.wr_reg(7'h6F, 8'h00, 8'h00, ok);
    `CHK(ok, 1'b0)
    // Unmapped index is acknowledged and dropped
    u_rcr_host_model.wr_reg(MAIN, 8'h40, 8'hAA, ok);
    `CHK(ok, 1'b1)
    // Sequences: zero wait, a frozen off wait, then the longest wait
    u_rcr_host_model.wr_reg(MAIN, 8'h17, 8'h00, ok);
    seq_run(1'b0, 0, 7'h00);
    seq_run(1'b1, 5, nvm_off);
    u_rcr_host_model.wr_reg(MAIN, 8'h17, 8'hFF, ok);
    seq_run(1'b0, 0, 7'h7F);
    give_verdict();
  end
endmodule
